// >>> src/wps_supervisor.sv
// wps_supervisor: main, zone and pool pump sequencing, flow, speed
// and overtemperature protection, backup heater gating.
// assumes all inputs synchronous to clk; registers on a plain port.
//
// What this block does
// RULE_01: pump on at start, no errors 70s
// RULE_02: early outdoor fault: compressor off, 3min hold
// RULE_03: low flow 60s latches pump, compressor off
// RULE_04: latched errors clear only on power reset
// RULE_05: pump stays on at thermostat compressor stop
// RULE_06: room, tank or buffer thermo off stops pump
// RULE_07: pump-off delayed 15s except deice, purge
// RULE_08: speed by delta-T or max duty, cap rules
// RULE_09: zone pump follows its zone request
// RULE_10: pool pump needs pool request and function
// RULE_11: zone1 hot 5min inhibits zone pumps 30min
// RULE_12: zone anti-freeze flag drives zone pumps
// RULE_13: indoor anti-freeze gated; pool unaffected
// RULE_14: deice pump-stop forces zone pumps off; code does so only when zone.buffer_tank is clear
// RULE_15: speed out of 700..6000 for 10s faults
// RULE_16: first fault 30s stop, second latches error
// RULE_17: inlet over 80C 10s stops pump
// RULE_18: restart pump after over 10min safety stop
// RULE_19: normal heater on needs all six conditions
// RULE_20: normal heater stop conditions, 15s filters
// RULE_21: forced heater mode on heat pump error
// RULE_22: heater inhibited by sensor, flow, pump stop
// RULE_23: all timers on one-second tick, clear on drop
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wps_supervisor
#(
  parameter int unsigned TICK_CYCLES = wps_pkg::TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // plant inputs
  input wire wps_pkg::wps_sense_type sense,
  input wire wps_pkg::wps_sys_type sys,
  input wire wps_pkg::wps_zone_type zone,
  input wire logic [12:0] dt_speed_rpm,
  // actuators
  output logic main_pump,
  output logic [12:0] pump_speed_rpm,
  output logic zone_one_circ_pump,
  output logic zone_two_circ_pump,
  output logic pool_circ_pump,
  output logic heater_on,
  output logic comp_enable,
  // indications
  output logic op_led_blink,
  output logic low_flow_error_code,
  output logic pump_speed_error_code
);
  import wps_pkg::*;

  // ==========================================================
  // one-second tick
  logic [23:0] tick_cnt_q;
  logic tick_q;
  // free-running divider; every timer advances on this pulse
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 24'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b1; // RULE_23
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // registers
  logic [31:0] ctrl_q;
  logic [31:0] setpt_q;
  logic [31:0] pump_q;
  logic [31:0] stat;
  logic signed [9:0] water_set, htr_od_set, on_ofs, off_ofs;
  logic [5:0] hp_delay_min;
  logic [12:0] max_speed;
  assign water_set = 10'(setpt_q[7:0]);
  assign htr_od_set = 10'(signed'(setpt_q[15:8]));
  assign on_ofs = 10'(signed'(setpt_q[23:16]));
  assign off_ofs = 10'(signed'(setpt_q[31:24]));
  assign hp_delay_min = pump_q[5:0];
  assign max_speed = pump_q[20:8];

  // software writes; one register per aligned word
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= CTRL_RST;
      setpt_q <= SETPT_RST;
      pump_q <= PUMP_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL: ctrl_q <= {30'h00000000, reg_wdata[1:0]};
        REG_SETPT: setpt_q <= reg_wdata;
        REG_PUMP: pump_q <= {11'h000, reg_wdata[20:8], 2'h0,
                             reg_wdata[5:0]};
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= ctrl_q;
        REG_SETPT: reg_rdata <= setpt_q;
        REG_PUMP: reg_rdata <= pump_q;
        REG_STAT: reg_rdata <= stat;
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end

  // ==========================================================
  // second timers
  logic [NT-1:0] t_cond;
  logic [NT-1:0] t_done;
  logic [11:0] t_lim [NT];
  logic [11:0] t_cnt_q [NT];
  logic lf_err_q, spd_err_q, retry_q, spd_seen_q, chold_q;
  logic safe_off_q, zinh_q, pump_req;
  logic signed [9:0] inlet, outlet, outdoor, zone1;
  logic spd_bad;
  assign inlet = 10'(sense.inlet);
  assign outlet = 10'(sense.outlet);
  assign outdoor = 10'(sense.outdoor);
  assign zone1 = 10'(sense.zone1);
  assign spd_bad = main_pump && ((sense.speed_rpm < SPD_LO_RPM) ||
                                 (sense.speed_rpm > SPD_HI_RPM));

  // conditions qualifying each timer
  always_comb
  begin
    t_cond = '0;
    t_cond[T_RUN] = sys.unit_on;
    t_cond[T_CHOLD] = chold_q;
    t_cond[T_LFLOW] = t_done[T_RUN] && sense.flow_low && !lf_err_q;
    t_cond[T_OFFDLY] = main_pump && !pump_req;
    t_cond[T_Z1HOT] = (zone1 >= ZONE_HOT_C) && !zinh_q;
    t_cond[T_ZINH] = zinh_q;
    t_cond[T_SPEED] = spd_bad && !retry_q;
    t_cond[T_RETRY] = retry_q;
    t_cond[T_FLOWON] = main_pump && sense.flow_sw_on;
    t_cond[T_HOT] = t_done[T_FLOWON] && (inlet > INLET_HOT_C);
    t_cond[T_SAFE] = safe_off_q;
    t_cond[T_PRUN] = main_pump;
    t_cond[T_HPON] = sys.hp_thermo_on;
    t_cond[T_HOFF] = !heater_on;
    t_cond[T_ODHI] = heater_on && (outdoor > htr_od_set + OD_HYST_C);
    t_cond[T_OUTHI] = heater_on && (outlet > water_set + off_ofs);
  end

  // one saturating counter per timer, cleared when its cause drops
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_tmr
      if (gi == T_HPON)
      begin : g_var
        assign t_lim[gi] = 12'(hp_delay_min * SEC_PER_MIN);
      end
      else
      begin : g_fix
        assign t_lim[gi] = LIM_S[gi];
      end
      assign t_done[gi] = t_cond[gi] && (t_cnt_q[gi] >= t_lim[gi]);
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          t_cnt_q[gi] <= 12'h000;
        else if (!t_cond[gi])
          t_cnt_q[gi] <= 12'h000; // RULE_23
        else if (tick_q && (t_cnt_q[gi] != 12'hFFF))
          t_cnt_q[gi] <= t_cnt_q[gi] + 12'h001; // RULE_23
      end
    end
  endgenerate

  // ==========================================================
  // error latches cleared by reset only; retry_q clears when its retry timer ends
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lf_err_q <= 1'b0;
      spd_err_q <= 1'b0;
      retry_q <= 1'b0;
      spd_seen_q <= 1'b0;
    end
    else
    begin
      if (t_done[T_LFLOW])
        lf_err_q <= 1'b1; // RULE_03 RULE_04
      if (t_done[T_SPEED] && spd_seen_q)
        spd_err_q <= 1'b1; // RULE_16 RULE_04
      if (t_done[T_SPEED] && !spd_seen_q)
      begin
        retry_q <= 1'b1; // RULE_15 RULE_16
        spd_seen_q <= 1'b1;
      end
      else if (t_done[T_RETRY])
        retry_q <= 1'b0; // RULE_16
    end
  end

  // early outdoor fault holds the compressor for three minutes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      chold_q <= 1'b0;
    else if (sys.unit_on && !t_done[T_RUN] && sys.outdoor_abn)
      chold_q <= 1'b1; // RULE_02
    else if (t_done[T_CHOLD])
      chold_q <= 1'b0; // RULE_02
  end

  // inlet overtemperature stop and its timed restart
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      safe_off_q <= 1'b0;
    else if (t_done[T_HOT])
      safe_off_q <= 1'b1; // RULE_17
    else if (t_done[T_SAFE])
      safe_off_q <= 1'b0; // RULE_18
  end

  // zone pump inhibit after a hot zone 1 circuit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      zinh_q <= 1'b0;
    else if (t_done[T_Z1HOT])
      zinh_q <= 1'b1; // RULE_11
    else if (t_done[T_ZINH])
      zinh_q <= 1'b0; // RULE_11
  end

  // ==========================================================
  // main pump and compressor
  logic pump_kill;
  // compressor thermostat stops are not a pump-off cause
  assign pump_req = sys.unit_on && !sys.room_thermo_off && // RULE_01
                    !sys.tank_thermo_off && !sys.buf_thermo_off; // RULE_06 RULE_05
  // protection stops act at once, bypassing the off delay
  assign pump_kill = lf_err_q || spd_err_q || retry_q || safe_off_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      main_pump <= 1'b0;
    else if (pump_kill)
      main_pump <= 1'b0; // RULE_03 RULE_16 RULE_17
    else if (pump_req)
      main_pump <= 1'b1; // RULE_01 RULE_18
    else if (t_done[T_OFFDLY] || sys.af_deice || sys.air_purge)
      main_pump <= 1'b0; // RULE_07
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      comp_enable <= 1'b0;
    else
      comp_enable <= sys.unit_on && !chold_q && !pump_kill; // RULE_02
  end

  // pump speed: capped delta-T, max duty, or uncapped sequences
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pump_speed_rpm <= 13'h0000;
    else if (!main_pump)
      pump_speed_rpm <= 13'h0000;
    else if (sys.pump_down || sys.air_purge || sys.normal_deice)
      pump_speed_rpm <= dt_speed_rpm; // RULE_08
    else if (!ctrl_q[CTRL_DELTA_T] && sys.room_side)
      pump_speed_rpm <= max_speed; // RULE_08
    else if (dt_speed_rpm > max_speed)
      pump_speed_rpm <= max_speed; // RULE_08
    else
      pump_speed_rpm <= dt_speed_rpm; // RULE_08
  end

  // ==========================================================
  // zone and pool pumps
  logic indoor_af_ok;
  assign indoor_af_ok = zone.indoor_af_active && zone.ext_board &&
                        !zone.buffer_tank; // RULE_13
  logic [1:0] zone_pump_q;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_zone
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          zone_pump_q[gi] <= 1'b0;
        else if (sys.af_deice_pump_stop && !zone.buffer_tank)
          zone_pump_q[gi] <= 1'b0; // RULE_14
        else if (zone.zone_af_active)
          zone_pump_q[gi] <= zone.zone_af_flag; // RULE_12
        else if (indoor_af_ok)
          zone_pump_q[gi] <= zone.indoor_af_flag; // RULE_13
        else
          zone_pump_q[gi] <= zone.zone_req[gi] && !zinh_q; // RULE_09 RULE_11
      end
    end
  endgenerate
  assign zone_one_circ_pump = zone_pump_q[0];
  assign zone_two_circ_pump = zone_pump_q[1];

  // pool pump ignores both anti-freeze controls
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pool_circ_pump <= 1'b0;
    else
      pool_circ_pump <= zone.pool_req && zone.pool_fn; // RULE_10 RULE_13
  end

  // ==========================================================
  // backup heater
  logic forced, htr_block, on_norm, stop_norm, on_force, stop_force;
  // pump and flow errors forbid forced heating
  assign forced = sys.hp_error && !lf_err_q && !spd_err_q; // RULE_21
  assign htr_block = sense.sensor_abn || sense.flow_abn ||
                     !main_pump || retry_q; // RULE_22 RULE_16
  assign on_norm = ctrl_q[CTRL_HTR_SW] && t_done[T_HPON] &&
                   t_done[T_PRUN] && (outdoor < htr_od_set) &&
                   (outlet < water_set + on_ofs) &&
                   t_done[T_HOFF]; // RULE_19
  assign stop_norm = t_done[T_ODHI] || t_done[T_OUTHI] ||
                     !ctrl_q[CTRL_HTR_SW] || !sys.hp_thermo_on; // RULE_20
  assign on_force = t_done[T_PRUN] && (outlet < water_set + on_ofs) &&
                    t_done[T_HOFF]; // RULE_21
  assign stop_force = t_done[T_OUTHI]; // RULE_21

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      heater_on <= 1'b0;
    else if (htr_block)
      heater_on <= 1'b0; // RULE_22
    else if (forced)
    begin
      if (heater_on && stop_force)
        heater_on <= 1'b0; // RULE_21
      else if (!heater_on && on_force)
        heater_on <= 1'b1; // RULE_21
    end
    else if (heater_on && (stop_norm || sys.hp_error))
      heater_on <= 1'b0; // RULE_20
    else if (!heater_on && on_norm)
      heater_on <= 1'b1; // RULE_19
  end

  // ==========================================================
  // indications
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_flow_error_code <= 1'b0;
      pump_speed_error_code <= 1'b0;
      op_led_blink <= 1'b0;
    end
    else
    begin
      low_flow_error_code <= lf_err_q; // RULE_03
      pump_speed_error_code <= spd_err_q; // RULE_16
      op_led_blink <= lf_err_q || spd_err_q; // RULE_03
    end
  end

  // status word for software
  assign stat = {22'h000000, t_done[T_RUN], forced, zinh_q,
                 safe_off_q, retry_q, spd_err_q, lf_err_q,
                 heater_on, comp_enable, main_pump};
endmodule : wps_supervisor
`default_nettype wire

// >>> src/wps_pkg.sv
// wps_pkg: constants, register map and carrier types for the
// hydronic pump and backup heater supervisor.
// assumes a 10 MHz system clock and temperatures in whole degrees C.
package wps_pkg;
  // ==========================================================
  // clock and one-second tick
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  // ==========================================================
  // second-scale timer indices
  localparam int NT = 16;
  localparam int T_RUN = 0;
  localparam int T_CHOLD = 1;
  localparam int T_LFLOW = 2;
  localparam int T_OFFDLY = 3;
  localparam int T_Z1HOT = 4;
  localparam int T_ZINH = 5;
  localparam int T_SPEED = 6;
  localparam int T_RETRY = 7;
  localparam int T_FLOWON = 8;
  localparam int T_HOT = 9;
  localparam int T_SAFE = 10;
  localparam int T_PRUN = 11;
  localparam int T_HPON = 12;
  localparam int T_HOFF = 13;
  localparam int T_ODHI = 14;
  localparam int T_OUTHI = 15;
  // timer limits in seconds; the safety wait must pass "more than" 600 s
  localparam logic [11:0] LIM_S [NT] = '{
    12'd70, 12'd180, 12'd60, 12'd15, 12'd300, 12'd1800, 12'd10,
    12'd30, 12'd10, 12'd10, 12'd601, 12'd180, 12'd0, 12'd1200,
    12'd15, 12'd15};
  localparam logic [11:0] SEC_PER_MIN = 12'd60;
  // ==========================================================
  // thresholds
  localparam logic [12:0] SPD_LO_RPM = 13'd700;
  localparam logic [12:0] SPD_HI_RPM = 13'd6000;
  localparam logic signed [9:0] ZONE_HOT_C = 10'sd75;
  localparam logic signed [9:0] INLET_HOT_C = 10'sd80;
  localparam logic signed [9:0] OD_HYST_C = 10'sd2;
  // ==========================================================
  // register map (byte offsets) and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETPT = 8'h04;
  localparam logic [7:0] REG_PUMP = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int CTRL_HTR_SW = 0;
  localparam int CTRL_DELTA_T = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] SETPT_RST = 32'h0503_F837;
  localparam logic [31:0] PUMP_RST = 32'h0017_7005;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic signed [7:0] inlet;
    logic signed [7:0] outlet;
    logic signed [7:0] outdoor;
    logic signed [7:0] zone1;
    logic sensor_abn;
    logic flow_abn;
    logic flow_low;
    logic flow_sw_on;
    logic [12:0] speed_rpm;
  } wps_sense_type;
  typedef struct packed {
    logic unit_on;
    logic outdoor_abn;
    logic room_thermo_off;
    logic tank_thermo_off;
    logic buf_thermo_off;
    logic hp_thermo_on;
    logic hp_error;
    logic af_deice;
    logic af_deice_pump_stop;
    logic air_purge;
    logic pump_down;
    logic normal_deice;
    logic room_side;
  } wps_sys_type;
  typedef struct packed {
    logic [1:0] zone_req;
    logic pool_req;
    logic pool_fn;
    logic zone_af_active;
    logic zone_af_flag;
    logic indoor_af_active;
    logic indoor_af_flag;
    logic ext_board;
    logic buffer_tank;
  } wps_zone_type;
endpackage : wps_pkg

// >>> test/wps_supervisor_monitor.sv
// wps_supervisor_monitor: port assertions for the supervisor.
// assumes it is bound onto wps_supervisor, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module wps_supervisor_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // plant inputs
  input wire wps_pkg::wps_sense_type sense,
  input wire wps_pkg::wps_sys_type sys,
  input wire wps_pkg::wps_zone_type zone,
  // actuators and indications
  input wire logic main_pump,
  input wire logic [12:0] pump_speed_rpm,
  input wire logic zone_one_circ_pump,
  input wire logic zone_two_circ_pump,
  input wire logic pool_circ_pump,
  input wire logic heater_on,
  input wire logic comp_enable,
  input wire logic op_led_blink,
  input wire logic low_flow_error_code,
  input wire logic pump_speed_error_code
);
  import wps_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================
  // pump-off request, with and without the delay exemption
  sequence s_purge_off;
    sys.air_purge && $rose(sys.room_thermo_off);
  endsequence
  sequence s_slow_off;
    !sys.air_purge && !sys.af_deice && $rose(sys.room_thermo_off)
      && main_pump;
  endsequence
  // ==========================================================
  // properties
  chk_pump_start: assert property ($rose(sys.unit_on) && !op_led_blink
    && !sys.room_thermo_off |=> main_pump)
    else $error("pump did not start with unit");
  chk_purge_fast: assert property (s_purge_off |-> ##[1:2] !main_pump)
    else $error("pump stop was delayed in purge");
  chk_off_delay: assert property (s_slow_off |=> main_pump[*8])
    else $error("pump stopped without delay");
  chk_flow_latch: assert property (low_flow_error_code
    |=> low_flow_error_code)
    else $error("low flow error released");
  chk_spd_latch: assert property (pump_speed_error_code
    |=> pump_speed_error_code)
    else $error("speed error released");
  chk_flow_stop: assert property (low_flow_error_code[*3]
    |-> !main_pump && !comp_enable)
    else $error("pump or compressor on after low flow");
  chk_led_err: assert property (low_flow_error_code
    || pump_speed_error_code |-> ##[0:1] op_led_blink)
    else $error("indicator not blinking on error");
  chk_heat_block: assert property (sense.sensor_abn || sense.flow_abn
    || !main_pump |=> !heater_on)
    else $error("heater on while inhibited");
  chk_pool_cause: assert property (pool_circ_pump
    |-> $past(zone.pool_req) && $past(zone.pool_fn))
    else $error("pool pump on without request");
  chk_zone_cause: assert property (zone_one_circ_pump
    |-> $past(zone.zone_req[0]) || $past(zone.zone_af_active)
    || $past(zone.indoor_af_active))
    else $error("zone pump on without cause");
  chk_speed_zero: assert property (!main_pump[*2]
    |-> pump_speed_rpm == 13'h0)
    else $error("speed command with pump off");
endmodule : wps_supervisor_monitor
bind wps_supervisor wps_supervisor_monitor u_mon (.clk(clk), .nrst(nrst),
  .sense(sense), .sys(sys), .zone(zone), .main_pump(main_pump),
  .pump_speed_rpm(pump_speed_rpm), .zone_one_circ_pump(zone_one_circ_pump),
  .zone_two_circ_pump(zone_two_circ_pump), .pool_circ_pump(pool_circ_pump),
  .heater_on(heater_on), .comp_enable(comp_enable),
  .op_led_blink(op_led_blink), .low_flow_error_code(low_flow_error_code),
  .pump_speed_error_code(pump_speed_error_code));
`default_nettype wire

// >>> test/wps_plant_model.sv
// wps_plant_model: water loop seen by the supervisor.
// assumes the bench commands the starve and jam faults.
`timescale 1ns/1ps
`default_nettype none
module wps_plant_model
(
  // clock
  input wire logic clk,
  // pump command
  input wire logic main_pump,
  input wire logic [12:0] pump_speed_rpm,
  // injected faults
  input wire logic starve,
  input wire logic jam,
  // feedback
  output logic flow_low,
  output logic flow_sw_on,
  output logic [12:0] speed_rpm
);
  // a stopped pump gives no flow and no speed, one cycle of lag
  always_ff @(posedge clk)
  begin
    flow_sw_on <= main_pump && !starve;
    flow_low <= !main_pump || starve;
    speed_rpm <= !main_pump ? 13'h0 : (jam ? 13'h1F4 : pump_speed_rpm);
  end
endmodule : wps_plant_model
`default_nettype wire

// >>> test/wps_supervisor_tb.sv
// wps_supervisor_tb: self-checking bench for the supervisor.
// assumes a ten-cycle tick so minute timers end quickly.
`timescale 1ns/1ps
`default_nettype none
module wps_supervisor_tb;
  import wps_pkg::*;
  localparam int TICK = 10;
  logic clk, nrst, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, r;
  wps_sense_type sense, sense_tb;
  wps_sys_type sys;
  wps_zone_type zone;
  logic [12:0] dt_speed_rpm, pump_speed_rpm, speed_rpm;
  logic main_pump, zone_one_circ_pump, zone_two_circ_pump, pool_circ_pump;
  logic heater_on, comp_enable, op_led_blink, starve, jam;
  logic low_flow_error_code, pump_speed_error_code, flow_low, flow_sw_on;
  int n_fail, checks_done, i;
  // ==========================================================
  // clock, plant feedback merged into the sensor bundle
  always #50 clk = ~clk;
  always_comb
  begin
    sense = sense_tb;
    sense.flow_low = flow_low;
    sense.flow_sw_on = flow_sw_on;
    sense.speed_rpm = speed_rpm;
  end
  wps_supervisor #(.TICK_CYCLES(TICK)) u_wps_supervisor (.clk(clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sense(sense), .sys(sys), .zone(zone), .dt_speed_rpm(dt_speed_rpm),
    .main_pump(main_pump), .pump_speed_rpm(pump_speed_rpm),
    .zone_one_circ_pump(zone_one_circ_pump),
    .zone_two_circ_pump(zone_two_circ_pump),
    .pool_circ_pump(pool_circ_pump), .heater_on(heater_on),
    .comp_enable(comp_enable), .op_led_blink(op_led_blink),
    .low_flow_error_code(low_flow_error_code),
    .pump_speed_error_code(pump_speed_error_code));
  wps_plant_model u_wps_plant_model (.clk(clk), .main_pump(main_pump),
    .pump_speed_rpm(pump_speed_rpm), .starve(starve), .jam(jam),
    .flow_low(flow_low), .flow_sw_on(flow_sw_on), .speed_rpm(speed_rpm));
  // ==========================================================
  // helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic rd_chk(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask : rd_chk
  task automatic do_reset;
    nrst <= 1'b0;
    wt(6);
    nrst <= 1'b1;
    wt(1);
  endtask : do_reset
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // zone pumps: deice stop, then zone, then indoor anti-freeze
  function automatic logic [2:0] zexp(input wps_zone_type z,
    input logic stop);
    logic [1:0] p;
    p = z.zone_req;
    if (z.indoor_af_active && z.ext_board && !z.buffer_tank)
      p = {2{z.indoor_af_flag}};
    if (z.zone_af_active)
      p = {2{z.zone_af_flag}};
    if (stop && !z.buffer_tank)
      p = 2'h0;
    return {z.pool_req && z.pool_fn, p};
  endfunction : zexp
  // ==========================================================
  // main sequence
  initial
  begin
    {clk, nrst, reg_wr, reg_rd, starve, jam} = '0;
    {reg_addr, reg_wdata, sys, zone} = '0;
    sense_tb = '0;
    {sense_tb.inlet, sense_tb.outlet, sense_tb.zone1} = {3{8'h1E}};
    sense_tb.outdoor = 8'hEC;
    dt_speed_rpm = 13'd3000;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'h9df8));
    do_reset();
    rd_chk("ctrl", REG_CTRL, CTRL_RST);
    rd_chk("setpt", REG_SETPT, SETPT_RST);
    rd_chk("pump", REG_PUMP, PUMP_RST);
    rd_chk("unmapped", 8'h10, 32'h0);
    reg_write(REG_STAT, 32'hFFFFFFFF);
    rd_chk("stat", REG_STAT, 32'h0);
    reg_write(REG_PUMP, 32'hFFFFFFFF);
    rd_chk("pump mask", REG_PUMP, 32'h001FFF3F);
    reg_write(REG_PUMP, 32'h00177000);
    // start, speed command in both modes
    {sys.unit_on, sys.hp_thermo_on, sys.room_side} <= 3'b111;
    wt(2);
    check("pump start", main_pump, 1'b1);
    check("comp start", comp_enable, 1'b1);
    r = $urandom_range(5999, 700);
    dt_speed_rpm <= r[12:0];
    wt(3);
    check("dt speed", pump_speed_rpm, r);
    dt_speed_rpm <= 13'd7000;
    wt(3);
    check("dt cap", pump_speed_rpm, 32'd6000);
    reg_write(REG_CTRL, 32'h0);
    reg_write(REG_PUMP, 32'h000FA000);
    wt(3);
    check("max duty", pump_speed_rpm, 32'd4000);
    // random zone and pool requests
    for (i = 0; i < 40; i++)
    begin
      r = $urandom;
      zone <= r[9:0];
      sys.af_deice_pump_stop <= r[11];
      wt(3);
      check("zones", {pool_circ_pump, zone_two_circ_pump,
        zone_one_circ_pump}, zexp(zone, r[11]));
    end
    zone <= '0;
    sys.af_deice_pump_stop <= 1'b0;
    // early outdoor fault holds the compressor
    sys.outdoor_abn <= 1'b1;
    wt(1);
    sys.outdoor_abn <= 1'b0;
    wt(2);
    check("comp off", comp_enable, 1'b0);
    wt(170 * TICK);
    check("comp hold", comp_enable, 1'b0);
    wt(20 * TICK);
    check("comp back", comp_enable, 1'b1);
    // pump-off request with delay, thermostat stop, purge
    sys.room_thermo_off <= 1'b1;
    wt(13 * TICK);
    check("off delay", main_pump, 1'b1);
    wt(4 * TICK);
    check("off done", main_pump, 1'b0);
    {sys.room_thermo_off, sys.hp_thermo_on} <= 2'b00;
    wt(20 * TICK);
    check("thermo stop", main_pump, 1'b1);
    {sys.air_purge, sys.room_thermo_off} <= 2'b11;
    wt(3);
    check("purge off", main_pump, 1'b0);
    {sys.air_purge, sys.room_thermo_off, sys.hp_thermo_on} <= 3'b001;
    // heater enable, then sensor fault blocks it
    reg_write(REG_CTRL, 32'h3);
    for (i = 0; i < 1600 && heater_on !== 1'b1; i++)
      wt(TICK);
    check("heater on", heater_on, 1'b1);
    if (heater_on !== 1'b1)
      wrap_up();
    sense_tb.sensor_abn <= 1'b1;
    wt(2);
    check("heater block", heater_on, 1'b0);
    sense_tb.sensor_abn <= 1'b0;
    // hot zone water inhibits zone pumps for a while
    zone.zone_req <= 2'h3;
    sense_tb.zone1 <= 8'd75;
    wt(295 * TICK);
    check("zone hot wait", zone_one_circ_pump, 1'b1);
    wt(10 * TICK);
    check("zone inhibit", zone_two_circ_pump, 1'b0);
    sense_tb.zone1 <= 8'd20;
    wt(1785 * TICK);
    check("inhibit hold", zone_one_circ_pump, 1'b0);
    wt(20 * TICK);
    check("inhibit end", zone_one_circ_pump, 1'b1);
    // speed fault: retry, then latched error
    jam <= 1'b1;
    wt(8 * TICK);
    check("spd filter", main_pump, 1'b1);
    wt(5 * TICK);
    check("spd stop", main_pump, 1'b0);
    wt(31 * TICK);
    check("spd retry", main_pump, 1'b1);
    wt(26 * TICK);
    check("spd error", pump_speed_error_code, 1'b1);
    check("spd pump", main_pump, 1'b0);
    {sys.unit_on, jam} <= 2'b00;
    wt(3);
    sys.unit_on <= 1'b1;
    wt(3);
    check("spd kept", pump_speed_error_code, 1'b1);
    sys.unit_on <= 1'b0;
    do_reset();
    check("spd cleared", pump_speed_error_code, 1'b0);
    // low flow after the start window
    {starve, sys.unit_on} <= 2'b11;
    wt(125 * TICK);
    check("flow window", low_flow_error_code, 1'b0);
    wt(10 * TICK);
    check("flow error", low_flow_error_code, 1'b1);
    check("flow pump", main_pump, 1'b0);
    check("flow comp", comp_enable, 1'b0);
    check("flow led", op_led_blink, 1'b1);
    {starve, sys.unit_on} <= 2'b00;
    wt(5 * TICK);
    sys.unit_on <= 1'b1;
    wt(5 * TICK);
    check("flow kept", low_flow_error_code, 1'b1);
    wrap_up();
  end
endmodule : wps_supervisor_tb
`default_nettype wire
